// ===== common/eiu_defines.svh
`ifndef EIU_DEFINES_SVH
`define EIU_DEFINES_SVH

// Register indexes; byte address is four times the index
`define EIU_IDX_PIN_MASK_A   6'h09
`define EIU_IDX_PIN_MASK_B   6'h0A
`define EIU_IDX_PENDING      6'h0B
`define EIU_IDX_ENABLE_MASK  6'h0C
`define EIU_IDX_PIN_MASK_C   6'h1A
`define EIU_IDX_SENSE_CTRL   6'h35

// Field positions
`define EIU_BIT_EXT          0
`define EIU_BIT_GRP_A        4
`define EIU_BIT_GRP_B        5
`define EIU_BIT_GRP_C        6
`define EIU_SENSE_HI         7
`define EIU_SENSE_LO         6

// Writable bits and reset values
`define EIU_ENABLE_WMASK     8'h71
`define EIU_PENDING_WMASK    8'h71
`define EIU_MASK_A_WMASK     8'hFF
`define EIU_MASK_B_WMASK     8'h0F
`define EIU_MASK_C_WMASK     8'h3F
`define EIU_REG_RESET        8'h00

// Sense encodings
`define EIU_SENSE_LOW        2'h0
`define EIU_SENSE_ANY        2'h1
`define EIU_SENSE_FALL       2'h2
`define EIU_SENSE_RISE       2'h3

// Vector table
`define EIU_VEC_RESET        5'h00
`define EIU_VEC_EXT          5'h01
`define EIU_VEC_GRP_A        5'h02
`define EIU_VEC_GRP_B        5'h03
`define EIU_VEC_GRP_C        5'h04
`define EIU_VEC_OTHER_FIRST  5'h05
`define EIU_VEC_LAST         5'h11

`endif

// ===== common/eiu_pkg.sv
package eiu_pkg;

  typedef logic [4:0]  eiu_vec_t;
  typedef logic [7:0]  eiu_byte_t;

  typedef struct packed {
    eiu_byte_t   enable_mask;
    eiu_byte_t   sense_ctrl;
    eiu_byte_t   pin_mask_a;
    eiu_byte_t   pin_mask_b;
    eiu_byte_t   pin_mask_c;
    logic        ext_pending;
    logic [2:0]  grp_pending;
    logic        ext_prev;
    logic [17:0] pin_prev;
    logic        wait_req;
    logic [31:0] rdata;
    logic        irq_req;
    eiu_vec_t    irq_vec;
    eiu_vec_t    reset_vec;
  } eiu_state_s;

endpackage

// ===== logic/eiu_core.sv
`timescale 1ns/100ps
`include "eiu_defines.svh"

// Overview of operation
// - Reset vector output is always program address zero.
// - External pin vector 1, toggle groups at vectors 2, 3, 4.
// - Other sources occupy vectors 5 to 0x11 in fixed order.
// - Pins raise requests regardless of their direction.
// - Group A flags on any enabled toggle of inputs 7 to 0.
// - Group B flags on any enabled toggle of inputs 11 to 8.
// - Group C flags on any enabled toggle of inputs 17 to 12.
// - Per-pin mask registers choose contributing pins of each group.
// - Toggle wake detection works without the clock.
// - Level mode requests as long as the pin stays low.
// - Edges are seen only on the clock.
// - Low-level wake detection works without the clock.
// - Low level gone before wake gives no interrupt.
// - External request needs global flag and its enable.
// - Sense field bits 7:6: low, any, falling, rising.
// - Pin is sampled before edge detection.
// - Enable mask: groups C,B,A bits 6,5,4, external bit 0.
// - Reserved enable mask bits read zero and ignore writes.
// - Group A reaches core with its enable and global flag.
// - Group B reaches core with its enable and global flag.
// - Group C reaches core with its enable and global flag.
// - External pending flag: set by edge, cleared by vector or one.
// - Group pending flags: set by toggle, cleared by vector or one.
module eiu_core (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // Pins
  input  wire logic        ext_pin_irq_i,
  input  wire logic [17:0] pin_toggle_input_i,
  // Core side
  input  wire logic        global_irq_en_i,
  input  wire logic [12:0] other_irq_i,
  input  wire logic        irq_ack_i,
  output logic             irq_req_o,
  output logic      [4:0]  irq_vector_o,
  output logic      [4:0]  reset_vector_o,
  output logic             wake_o
);

  eiu_pkg::eiu_state_s state_ff;
  eiu_pkg::eiu_state_s nxt_state;

  logic [17:0] toggles;
  logic [2:0]  grp_hit;
  logic        ext_hit;
  logic        ext_level;
  logic [17:1] req;
  logic [1:0]  sense;
  logic [5:0]  idx;
  logic        rd_acc;
  logic        wr_acc;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [4:0]  win_vec;
  logic        win_any;

  // Clockless wake path; the pin sample only remembers the last level seen
  always_comb begin
    wake_o = 1'b0;
    if (|((pin_toggle_input_i ^ state_ff.pin_prev) &
          {state_ff.pin_mask_c[5:0], state_ff.pin_mask_b[3:0],
           state_ff.pin_mask_a}))
      wake_o = 1'b1;
    if (state_ff.enable_mask[`EIU_BIT_EXT] && !ext_pin_irq_i &&
        state_ff.sense_ctrl[`EIU_SENSE_HI:`EIU_SENSE_LO] == `EIU_SENSE_LOW)
      wake_o = 1'b1;
  end

  always_comb begin
    nxt_state = state_ff;
    sense     = state_ff.sense_ctrl[`EIU_SENSE_HI:`EIU_SENSE_LO];
    idx       = address_i[7:2];
    rd_acc    = read_i && !write_i;
    wr_acc    = write_i && !read_i && !state_ff.wait_req &&
                byteenable_i[0];
    wbyte     = writedata_i[7:0];
    rbyte     = 8'h00;
    win_vec   = `EIU_VEC_RESET;
    win_any   = 1'b0;

    // Pins are taken as driven, input or output alike
    nxt_state.pin_prev = pin_toggle_input_i;
    nxt_state.ext_prev = ext_pin_irq_i;

    // Toggle detection per enabled pin
    toggles = (pin_toggle_input_i ^ state_ff.pin_prev) &
              {state_ff.pin_mask_c[5:0], state_ff.pin_mask_b[3:0],
               state_ff.pin_mask_a};
    grp_hit[0] = |toggles[7:0];
    grp_hit[1] = |toggles[11:8];
    grp_hit[2] = |toggles[17:12];

    // Edge sensing off the sampled pin
    unique case (sense)
      `EIU_SENSE_ANY:  ext_hit = ext_pin_irq_i ^ state_ff.ext_prev;
      `EIU_SENSE_FALL: ext_hit = state_ff.ext_prev && !ext_pin_irq_i;
      `EIU_SENSE_RISE: ext_hit = !state_ff.ext_prev && ext_pin_irq_i;
      default:         ext_hit = 1'b0;
    endcase
    // Level request lasts only while the pin is low
    ext_level = (sense == `EIU_SENSE_LOW) && !ext_pin_irq_i;

    // Register reads
    unique case (idx)
      `EIU_IDX_ENABLE_MASK: rbyte = state_ff.enable_mask;
      `EIU_IDX_SENSE_CTRL:  rbyte = state_ff.sense_ctrl;
      `EIU_IDX_PIN_MASK_A:  rbyte = state_ff.pin_mask_a;
      `EIU_IDX_PIN_MASK_B:  rbyte = state_ff.pin_mask_b;
      `EIU_IDX_PIN_MASK_C:  rbyte = state_ff.pin_mask_c;
      `EIU_IDX_PENDING: begin
        rbyte[`EIU_BIT_EXT]   = state_ff.ext_pending;
        rbyte[`EIU_BIT_GRP_A] = state_ff.grp_pending[0];
        rbyte[`EIU_BIT_GRP_B] = state_ff.grp_pending[1];
        rbyte[`EIU_BIT_GRP_C] = state_ff.grp_pending[2];
      end
      default: rbyte = 8'h00;
    endcase

    // One wait cycle, then answer; write lands on the edge after the answer
    if ((rd_acc || write_i) && state_ff.wait_req) begin
      nxt_state.wait_req = 1'b0;
      nxt_state.rdata    = {24'h00_0000, rbyte};
    end else begin
      nxt_state.wait_req = 1'b1;
    end

    if (wr_acc) begin
      unique case (idx)
        `EIU_IDX_ENABLE_MASK:
          nxt_state.enable_mask = wbyte & `EIU_ENABLE_WMASK;
        `EIU_IDX_SENSE_CTRL:  nxt_state.sense_ctrl = wbyte;
        `EIU_IDX_PIN_MASK_A:
          nxt_state.pin_mask_a = wbyte & `EIU_MASK_A_WMASK;
        `EIU_IDX_PIN_MASK_B:
          nxt_state.pin_mask_b = wbyte & `EIU_MASK_B_WMASK;
        `EIU_IDX_PIN_MASK_C:
          nxt_state.pin_mask_c = wbyte & `EIU_MASK_C_WMASK;
        `EIU_IDX_PENDING: begin
          // Write one to clear
          if (wbyte[`EIU_BIT_EXT])   nxt_state.ext_pending    = 1'b0;
          if (wbyte[`EIU_BIT_GRP_A]) nxt_state.grp_pending[0] = 1'b0;
          if (wbyte[`EIU_BIT_GRP_B]) nxt_state.grp_pending[1] = 1'b0;
          if (wbyte[`EIU_BIT_GRP_C]) nxt_state.grp_pending[2] = 1'b0;
        end
        default: ;
      endcase
    end

    // Vector execution clears its own flag
    if (irq_ack_i && state_ff.irq_req) begin
      unique case (state_ff.irq_vec)
        `EIU_VEC_EXT:   nxt_state.ext_pending    = 1'b0;
        `EIU_VEC_GRP_A: nxt_state.grp_pending[0] = 1'b0;
        `EIU_VEC_GRP_B: nxt_state.grp_pending[1] = 1'b0;
        `EIU_VEC_GRP_C: nxt_state.grp_pending[2] = 1'b0;
        default: ;
      endcase
    end

    // Set after clear so a new event is never lost
    if (ext_hit)    nxt_state.ext_pending    = 1'b1;
    if (grp_hit[0]) nxt_state.grp_pending[0] = 1'b1;
    if (grp_hit[1]) nxt_state.grp_pending[1] = 1'b1;
    if (grp_hit[2]) nxt_state.grp_pending[2] = 1'b1;
    // Flag held clear in level mode
    if (nxt_state.sense_ctrl[`EIU_SENSE_HI:`EIU_SENSE_LO] == `EIU_SENSE_LOW)
      nxt_state.ext_pending = 1'b0;

    // Gated request lines, indexed by vector address
    req[1] = global_irq_en_i && state_ff.enable_mask[`EIU_BIT_EXT] &&
             (state_ff.ext_pending || ext_level);
    req[2] = global_irq_en_i && state_ff.enable_mask[`EIU_BIT_GRP_A] &&
             state_ff.grp_pending[0];
    req[3] = global_irq_en_i && state_ff.enable_mask[`EIU_BIT_GRP_B] &&
             state_ff.grp_pending[1];
    req[4] = global_irq_en_i && state_ff.enable_mask[`EIU_BIT_GRP_C] &&
             state_ff.grp_pending[2];
    req[17:5] = global_irq_en_i ? other_irq_i : 13'h0000;

    // Scan downward so the lowest address is the last to win
    for (int i = 17; i >= 1; i--) begin
      if (req[i]) begin
        win_vec = 5'(i);
        win_any = 1'b1;
      end
    end
    // Hold the offered vector stable for the ack cycle
    if (!(state_ff.irq_req && irq_ack_i)) begin
      nxt_state.irq_req = win_any;
      nxt_state.irq_vec = win_vec;
    end else begin
      nxt_state.irq_req = 1'b0;
    end
    nxt_state.reset_vec = `EIU_VEC_RESET;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff             <= '0;
      state_ff.enable_mask <= `EIU_REG_RESET;
      state_ff.sense_ctrl  <= `EIU_REG_RESET;
      state_ff.wait_req    <= 1'b1;
      state_ff.pin_prev    <= 18'h0_0000;
      state_ff.reset_vec   <= `EIU_VEC_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign readdata_o     = state_ff.rdata;
  assign waitrequest_o  = state_ff.wait_req;
  assign irq_req_o      = state_ff.irq_req;
  assign irq_vector_o   = state_ff.irq_vec;
  assign reset_vector_o = state_ff.reset_vec;

endmodule

// ===== test/eiu_props.sv
`timescale 1ns/100ps
module eiu_props (
  // Watched ports
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic        waitrequest_o,
  input wire logic [31:0] readdata_o,
  input wire logic        global_irq_en_i,
  input wire logic        irq_ack_i,
  input wire logic        irq_req_o,
  input wire logic [4:0]  irq_vector_o,
  input wire logic [4:0]  reset_vector_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_reset_vec_zero: assert property (reset_vector_o == 5'h00)
    else $error("reset vector not zero");
  chk_bus_answer: assert property ((read_i ^ write_i) && waitrequest_o
    |=> !waitrequest_o) else $error("bus access not answered");
  chk_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait low too long");
  chk_idle_wait: assert property (!read_i && !write_i |=> waitrequest_o)
    else $error("answer without request");
  chk_rdata_high: assert property (readdata_o[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_irq_gated: assert property (irq_req_o |-> $past(global_irq_en_i))
    else $error("request with global flag off");
  chk_vec_range: assert property (irq_req_o
    |-> irq_vector_o inside {[5'h01:5'h11]}) else $error("bad vector");
  chk_ack_drop: assert property (irq_req_o && irq_ack_i |=> !irq_req_o)
    else $error("request kept after ack");
endmodule

// ===== test/eiu_core_model.sv
`timescale 1ns/100ps
module eiu_core_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Offered vector and control
  input  wire logic       irq_req_i,
  input  wire logic [4:0] irq_vector_i,
  input  wire logic       auto_i,
  input  wire logic [3:0] delay_i,
  output logic            irq_ack_o,
  output logic      [4:0] last_vec_o
);
  logic [3:0] wait_ff;
  // Stall models a core busy finishing its current instruction
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ack_o  <= 1'b0;
      last_vec_o <= 5'h00;
      wait_ff    <= 4'h0;
    end else begin
      irq_ack_o <= 1'b0;
      if (irq_ack_o || !auto_i || !irq_req_i) begin
        wait_ff <= 4'h0;
      end else if (wait_ff == delay_i) begin
        irq_ack_o  <= 1'b1;
        last_vec_o <= irq_vector_i;
        wait_ff    <= 4'h0;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule

// ===== test/tb.sv
`timescale 1ns/100ps
module tb;
  logic        clock_i, rst_n_i, read_i, write_i, waitrequest_o, wake_o;
  logic        ext_pin_irq_i, global_irq_en_i, irq_ack_i, irq_req_o, auto;
  logic [7:0]  address_i;
  logic [31:0] writedata_i, readdata_o;
  logic [3:0]  byteenable_i, dly;
  logic [17:0] pin_toggle_input_i;
  logic [12:0] other_irq_i;
  logic [4:0]  irq_vector_o, reset_vector_o, last_vec;
  int          fail_count, total_checks;
  eiu_core i_eiu_core (.clock_i, .rst_n_i, .address_i, .read_i, .write_i,
    .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o,
    .ext_pin_irq_i, .pin_toggle_input_i, .global_irq_en_i, .other_irq_i,
    .irq_ack_i, .irq_req_o, .irq_vector_o, .reset_vector_o, .wake_o);
  eiu_core_model u_core (.clock_i, .rst_n_i, .irq_req_i(irq_req_o),
    .irq_vector_i(irq_vector_o), .auto_i(auto), .delay_i(dly),
    .irq_ack_o(irq_ack_i), .last_vec_o(last_vec));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic we, input logic [5:0] idx, input logic [7:0] wd,
           output logic [7:0] rd);
    @(posedge clock_i);
    address_i   <= {idx, 2'b00};
    writedata_i <= {24'h00_0000, wd};
    read_i      <= !we;
    write_i     <= we;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o[7:0];
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask
  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] rd;
    bus(1'b1, idx, d, rd);
  endtask
  task rdc(input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    chk({24'h00_0000, rd}, {24'h00_0000, exp});
  endtask
  task t_regs;
    rdc(6'h0C, 8'h00);
    chk({27'h000_0000, reset_vector_o}, 32'h0000_0000);
    wr(6'h0C, 8'hFF);
    rdc(6'h0C, 8'h71);
    wr(6'h0A, 8'hFF);
    rdc(6'h0A, 8'h0F);
    wr(6'h35, 8'hC5);
    rdc(6'h35, 8'hC5);
    wr(6'h3F, 8'hFF);
    rdc(6'h3F, 8'h00);
    wr(6'h0C, 8'h00);
  endtask
  task t_groups;
    wr(6'h09, 8'h08);
    wr(6'h0A, 8'h02);
    wr(6'h1A, 8'h08);
    for (int g = 0; g < 3; g++) begin
      pin_toggle_input_i[2+6*g] <= 1'b1;
      tick(3);
      rdc(6'h0B, 8'h00);
      wr(6'h0C, 8'h10 << g);
      global_irq_en_i <= 1'b1;
      pin_toggle_input_i[3+6*g] <= 1'b1;
      tick(12);
      chk({27'h000_0000, last_vec}, 32'(2 + g));
      rdc(6'h0B, 8'h00);
      global_irq_en_i <= 1'b0;
      wr(6'h0C, 8'h00);
    end
  endtask
  task t_priority;
    auto <= 1'b0;
    dly  <= 4'h0;
    wr(6'h0C, 8'h50);
    pin_toggle_input_i[3]  <= 1'b0;
    pin_toggle_input_i[15] <= 1'b0;
    tick(1);
    chk({31'h0000_0000, wake_o}, 32'h0000_0001);
    tick(3);
    chk({31'h0000_0000, irq_req_o}, 32'h0000_0000);
    global_irq_en_i <= 1'b1;
    tick(3);
    chk({27'h000_0000, irq_vector_o}, 32'h0000_0002);
    auto <= 1'b1;
    tick(12);
    chk({27'h000_0000, last_vec}, 32'h0000_0004);
    auto <= 1'b0;
    wr(6'h0C, 8'h00);
    other_irq_i <= 13'h1000;
    tick(3);
    chk({27'h000_0000, irq_vector_o}, 32'h0000_0011);
    other_irq_i     <= 13'h0000;
    global_irq_en_i <= 1'b0;
  endtask
  task t_ext;
    wr(6'h0C, 8'h01);
    for (int s = 1; s < 4; s++) begin
      wr(6'h35, 8'(s << 6));
      wr(6'h0B, 8'h01);
      ext_pin_irq_i <= 1'b0;
      tick(3);
      rdc(6'h0B, (s != 3) ? 8'h01 : 8'h00);
      wr(6'h0B, 8'h01);
      rdc(6'h0B, 8'h00);
      ext_pin_irq_i <= 1'b1;
      tick(3);
      rdc(6'h0B, (s != 2) ? 8'h01 : 8'h00);
    end
    wr(6'h35, 8'h00);
    global_irq_en_i <= 1'b1;
    ext_pin_irq_i   <= 1'b0;
    tick(4);
    chk({26'h000_0000, irq_req_o, irq_vector_o}, 32'h0000_0021);
    chk({31'h0000_0000, wake_o}, 32'h0000_0001);
    rdc(6'h0B, 8'h00);
    ext_pin_irq_i   <= 1'b1;
    global_irq_en_i <= 1'b0;
  endtask
  task tally_and_finish;
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst_n_i, read_i, write_i, global_irq_en_i, auto} = 5'b0_0001;
    {address_i, writedata_i, other_irq_i, pin_toggle_input_i} = '0;
    {ext_pin_irq_i, byteenable_i, dly} = 9'h1_13;
    tick(20);
    rst_n_i <= 1'b1;
    t_regs;
    t_groups;
    t_priority;
    t_ext;
    tally_and_finish;
  end
  // Run needs a few hundred cycles; generous margin
  initial begin
    tick(4000);
    fail_count++;
    tally_and_finish;
  end
endmodule
bind eiu_core eiu_props u_props (.clock_i, .rst_n_i, .read_i, .write_i,
  .waitrequest_o, .readdata_o, .global_irq_en_i, .irq_ack_i, .irq_req_o,
  .irq_vector_o, .reset_vector_o);
